// [src/ppm_defines.svh]
// Purpose: constants for the peripheral pin selection block
// Assumes: 32-bit register words on an AXI4-Lite slave
// Notes: byte offsets, field positions, reset values
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH

`define PPM_OFF_STRAP 12'h000
`define PPM_OFF_SEL 12'h004
`define PPM_OFF_GPEN 12'h008
`define PPM_OFF_GPDIR 12'h00C
`define PPM_OFF_GPOUT 12'h010
`define PPM_OFF_GPIN 12'h014

`define PPM_BIT_CELL 0
`define PPM_BIT_PCI 1
`define PPM_BIT_S2 2
`define PPM_BIT_AUTO 3

`define PPM_BIT_S1_EN 0
`define PPM_BIT_CELL_EN 1
`define PPM_BIT_HOST_EN 2
`define PPM_BIT_PCI_EN 3
`define PPM_BIT_S2_EN 4
`define PPM_BIT_EE_EN 5
`define PPM_BIT_UGP_EN 6
`define PPM_BIT_AUTOLOAD 7

`define PPM_RST_GP 7'h00
`define PPM_RESP_OKAY 2'h0
`define PPM_RESP_SLVERR 2'h2

`endif

// [src/ppm_pkg.sv]
// Purpose: shared types for the peripheral pin selection block
// Assumes: nothing beyond the defines header
// Notes: carriers for straps and selection outputs
`default_nettype none
package ppm_pkg;
    typedef struct packed {
        logic cell_port_select_strap;
        logic pci_select;
        logic serial_two_select_pin;
        logic eeprom_autoinit_strap;
    } ppm_straps_t;

    typedef struct packed {
        logic serial_one_en;
        logic cell_port_en;
        logic host_port_en;
        logic pci_port_en;
        logic serial_two_en;
        logic eeprom_en;
        logic upper_gpio_avail;
        logic pci_autoload;
    } ppm_sel_t;

    typedef struct packed {
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [2:0] sync_c;
    } ppm_sync_state_t;
endpackage : ppm_pkg
`default_nettype wire

// [src/ppm_pin_sync.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input from outside the sys_clk domain
// Notes: output changes once stages two and three agree
`default_nettype none
module ppm_pin_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic [2:0] stage;
    logic next_level;

    always_comb begin
        next_level = level;
        if (stage[1] == stage[2]) begin
            next_level = stage[1];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= {3{RESET_VALUE}};
            level <= RESET_VALUE;
        end else begin
            stage <= {stage[1:0], pin};
            level <= next_level;
        end
    end
endmodule : ppm_pin_sync
`default_nettype wire

// [src/ppm_pin_select.sv]
// Purpose: reset-latched peripheral selection and shared pin ownership
// Assumes: straps held stable by the board around reset release
// Notes: registers on AXI4-Lite; strap capture at the end of reset
`include "ppm_defines.svh"
`default_nettype none
// Notes on behaviour
// - straps are captured on the first clock after reset release; all but serial two select are kept as configuration afterwards.
// - each shared pin has exactly one owner among the muxed peripherals.
// - cell strap 0 gives shared pins to serial one; cell standalone pins float.
// - cell strap 1 gives shared pins to cell port; serial one standalone floats.
// - pci select 0 enables host port and frees upper gpio for software.
// - pci select 0 floats byte-enable-zero and eeprom chip select.
// - pci select 1 disables host port; shared host pins go to pci.
// - pci select 1 gives shared gpio pins to pci.
// - serial two off only when pci select 1 and serial two select 0.
// - that combination with autoinit strap 1 loads pci from eeprom.
// - serial two select may rise later, enabling serial two, no reset.
// - upper gpio works only with pci off and enable, direction bits set.
// - coprocessors, timers, serial zero, lower gpio are always available.
// - autoinit strap 0 means pci uses built-in defaults.
module ppm_pin_select (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic cell_select_address_pin,
    input wire logic pci_select_pin,
    input wire logic serial_two_select_pin,
    input wire logic autoinit_address_pin,
    input wire logic [6:0] upper_gpio_in,
    output logic [6:0] upper_gpio_out,
    output logic [6:0] upper_gpio_oe,
    output logic shared_s1_cell_oe_s1,
    output logic shared_s1_cell_oe_cell,
    output logic cell_standalone_oe,
    output logic s1_standalone_oe,
    output logic shared_host_pci_oe_host,
    output logic shared_host_pci_oe_pci,
    output logic byte_enable_zero_oe,
    output logic eeprom_chip_select_oe,
    output logic shared_s2_pci_oe_s2,
    output logic shared_s2_pci_oe_pci,
    output ppm_pkg::ppm_sel_t sel,
    output logic always_on_en,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    typedef struct packed {
        logic captured;
        ppm_pkg::ppm_straps_t strap;
        ppm_pkg::ppm_sel_t sel;
        logic [6:0] gp_en;
        logic [6:0] gp_dir;
        logic [6:0] gp_out;
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ppm_state_t;

    ppm_state_t st;
    ppm_state_t next_st;
    logic [1:0] rst_sync;
    logic rst_n;
    logic [3:0] pin_level;
    logic [6:0] gp_in_level;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_fire;

    // reset assert asynchronous, release through two flip-flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // strap synchronisers keep sampling while reset is held, so capture sees settled levels
    ppm_pin_sync #(.RESET_VALUE(1'b0)) u_sync_cell (.sys_clk(sys_clk), .rst_n(1'b1),
        .pin(cell_select_address_pin), .level(pin_level[`PPM_BIT_CELL]));
    ppm_pin_sync #(.RESET_VALUE(1'b0)) u_sync_pci (.sys_clk(sys_clk), .rst_n(1'b1),
        .pin(pci_select_pin), .level(pin_level[`PPM_BIT_PCI]));
    ppm_pin_sync #(.RESET_VALUE(1'b0)) u_sync_s2 (.sys_clk(sys_clk), .rst_n(1'b1),
        .pin(serial_two_select_pin), .level(pin_level[`PPM_BIT_S2]));
    ppm_pin_sync #(.RESET_VALUE(1'b0)) u_sync_auto (.sys_clk(sys_clk), .rst_n(1'b1),
        .pin(autoinit_address_pin), .level(pin_level[`PPM_BIT_AUTO]));

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_gpin
            ppm_pin_sync #(.RESET_VALUE(1'b0)) u_sync_gp (.sys_clk(sys_clk),
                .rst_n(rst_n), .pin(upper_gpio_in[gi]), .level(gp_in_level[gi]));
        end
    endgenerate

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `PPM_OFF_STRAP: rd_word = {28'h0, st.strap.eeprom_autoinit_strap,
                st.strap.serial_two_select_pin, st.strap.pci_select,
                st.strap.cell_port_select_strap};
            `PPM_OFF_SEL: rd_word = {24'h0, st.sel};
            `PPM_OFF_GPEN: rd_word = {25'h0, st.gp_en};
            `PPM_OFF_GPDIR: rd_word = {25'h0, st.gp_dir};
            `PPM_OFF_GPOUT: rd_word = {25'h0, st.gp_out};
            `PPM_OFF_GPIN: rd_word = {25'h0, gp_in_level};
            default: rd_ok = 1'b0;
        endcase
    end

    assign wr_fire = st.aw_have && st.w_have && !st.bvalid;

    always_comb begin
        ppm_pkg::ppm_straps_t s;
        s = st.strap;
        next_st = st;
        // straps taken from the synchronised pins on the first clock after release; serial two select keeps following
        if (!st.captured) begin
            s.cell_port_select_strap = pin_level[`PPM_BIT_CELL];
            s.pci_select = pin_level[`PPM_BIT_PCI];
            s.serial_two_select_pin = pin_level[`PPM_BIT_S2];
            s.eeprom_autoinit_strap = pin_level[`PPM_BIT_AUTO];
            next_st.captured = 1'b1;
        end else begin
            s.serial_two_select_pin = pin_level[`PPM_BIT_S2];
        end
        next_st.strap = s;
        next_st.sel.serial_one_en = !s.cell_port_select_strap;
        next_st.sel.cell_port_en = s.cell_port_select_strap;
        next_st.sel.host_port_en = !s.pci_select;
        next_st.sel.pci_port_en = s.pci_select;
        next_st.sel.upper_gpio_avail = !s.pci_select;
        next_st.sel.serial_two_en = !(s.pci_select && !s.serial_two_select_pin);
        next_st.sel.eeprom_en = s.pci_select && !s.serial_two_select_pin;
        // autoload decided at capture, cleared for good once serial two select is high
        if (!st.captured) begin
            next_st.sel.pci_autoload = pin_level[`PPM_BIT_PCI] && !pin_level[`PPM_BIT_S2]
                && pin_level[`PPM_BIT_AUTO];
        end else if (s.serial_two_select_pin) begin
            next_st.sel.pci_autoload = 1'b0;
        end

        if (s_axi_awvalid && !st.aw_have) begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_have) begin
            next_st.w_have = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `PPM_RESP_OKAY;
            case (st.aw_addr)
                `PPM_OFF_GPEN: if (st.w_strb[0]) next_st.gp_en = st.w_data[6:0];
                `PPM_OFF_GPDIR: if (st.w_strb[0]) next_st.gp_dir = st.w_data[6:0];
                `PPM_OFF_GPOUT: if (st.w_strb[0]) next_st.gp_out = st.w_data[6:0];
                `PPM_OFF_STRAP, `PPM_OFF_SEL, `PPM_OFF_GPIN: next_st.bresp = `PPM_RESP_OKAY;
                default: next_st.bresp = `PPM_RESP_SLVERR;
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word;
            next_st.rresp = rd_ok ? `PPM_RESP_OKAY : `PPM_RESP_SLVERR;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st.captured <= 1'b0;
            st.strap <= 4'h0;
            st.sel <= 8'h00;
            st.gp_en <= `PPM_RST_GP;
            st.gp_dir <= `PPM_RST_GP;
            st.gp_out <= `PPM_RST_GP;
            st.aw_have <= 1'b0;
            st.aw_addr <= 12'h000;
            st.w_have <= 1'b0;
            st.w_data <= 32'h0000_0000;
            st.w_strb <= 4'h0;
            st.bvalid <= 1'b0;
            st.bresp <= 2'h0;
            st.rvalid <= 1'b0;
            st.rdata <= 32'h0000_0000;
            st.rresp <= 2'h0;
        end else begin
            st.captured <= next_st.captured;
            st.strap <= next_st.strap;
            st.sel <= next_st.sel;
            st.gp_en <= next_st.gp_en;
            st.gp_dir <= next_st.gp_dir;
            st.gp_out <= next_st.gp_out;
            st.aw_have <= next_st.aw_have;
            st.aw_addr <= next_st.aw_addr;
            st.w_have <= next_st.w_have;
            st.w_data <= next_st.w_data;
            st.w_strb <= next_st.w_strb;
            st.bvalid <= next_st.bvalid;
            st.bresp <= next_st.bresp;
            st.rvalid <= next_st.rvalid;
            st.rdata <= next_st.rdata;
            st.rresp <= next_st.rresp;
        end
    end

    // one owner per shared pin, all enables from registered selection
    assign shared_s1_cell_oe_s1 = st.captured && st.sel.serial_one_en;
    assign shared_s1_cell_oe_cell = st.captured && st.sel.cell_port_en;
    assign cell_standalone_oe = st.captured && st.sel.cell_port_en;
    assign s1_standalone_oe = st.captured && st.sel.serial_one_en;
    assign shared_host_pci_oe_host = st.captured && st.sel.host_port_en;
    assign shared_host_pci_oe_pci = st.captured && st.sel.pci_port_en;
    assign byte_enable_zero_oe = st.captured && st.sel.pci_port_en;
    assign eeprom_chip_select_oe = st.captured && st.sel.eeprom_en;
    assign shared_s2_pci_oe_s2 = st.captured && st.sel.serial_two_en;
    assign shared_s2_pci_oe_pci = st.captured && !st.sel.serial_two_en;
    // upper gpio driven only with pci off and enable and direction set
    assign upper_gpio_oe = (st.captured && st.sel.upper_gpio_avail) ?
        (st.gp_en & st.gp_dir) : 7'h00;
    assign upper_gpio_out = st.gp_out;
    assign sel = st.sel;
    assign always_on_en = 1'b1;

    assign s_axi_awready = !st.aw_have;
    assign s_axi_wready = !st.w_have;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    sequence seq_pci_no_s2;
        st.strap.pci_select && !st.strap.serial_two_select_pin;
    endsequence

    AST_S1_CELL_EXCL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(shared_s1_cell_oe_s1 && shared_s1_cell_oe_cell))
        else $error("serial one and cell port both drive shared pins");
    AST_CELL0: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.captured && !st.strap.cell_port_select_strap |=> !cell_standalone_oe)
        else $error("cell standalone pins driven with strap 0");
    AST_CELL1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.captured && st.strap.cell_port_select_strap |=> !s1_standalone_oe)
        else $error("serial one standalone pins driven with strap 1");
    AST_HOST: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.captured && !st.strap.pci_select |=> shared_host_pci_oe_host)
        else $error("host port not enabled with pci select 0");
    AST_PCI0_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.captured && !st.strap.pci_select |=> !byte_enable_zero_oe && !eeprom_chip_select_oe)
        else $error("pci standalone pins driven with pci select 0");
    AST_PCI1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.captured && st.strap.pci_select |=> shared_host_pci_oe_pci && !shared_host_pci_oe_host)
        else $error("host pins not given to pci");
    AST_GPIO_PCI: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.sel.pci_port_en |-> upper_gpio_oe == 7'h00)
        else $error("upper gpio driven while pci owns them");
    AST_S2_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st.captured and seq_pci_no_s2) |-> !st.sel.serial_two_en)
        else $error("serial two enabled in the one disabling combination");
    AST_S2_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.captured && $rose(st.strap.serial_two_select_pin) |-> st.sel.serial_two_en
        && !st.sel.eeprom_en)
        else $error("serial two not enabled after select rose");
    AST_PCI_FIXED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.captured |=> $stable(st.strap.pci_select) && $stable(st.strap.cell_port_select_strap))
        else $error("latched selects changed after capture");
endmodule : ppm_pin_select
`default_nettype wire

// [verification/ppm_strap_board.sv]
// Purpose: board side of the selection pins: strap resistors and select driver
// Assumes: bench asks for pin levels through the want_ inputs
// Notes: pci select only follows a request while the device is held in reset
`default_nettype none
module ppm_strap_board (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic want_cell,
    input wire logic want_pci,
    input wire logic want_s2,
    input wire logic want_auto,
    output logic cell_pin,
    output logic pci_pin,
    output logic s2_pin,
    output logic auto_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cell_pin = 1'h0;
        pci_pin = 1'h0;
        s2_pin = 1'h0;
        auto_pin = 1'h0;
    end
    always @(posedge sys_clk) begin
        cell_pin <= want_cell;
        if (!resetn) begin
            pci_pin <= want_pci;
        end
        s2_pin <= want_s2;
        auto_pin <= want_auto & (resetn ? pci_pin : want_pci);
    end
endmodule : ppm_strap_board
`default_nettype wire

// [verification/peripheral_pin_mux_select_bench.sv]
// Purpose: self-checking bench for the peripheral pin selection block
// Assumes: straps settle before reset release; AXI4-Lite register access
// Notes: every strap combination the board may fit is captured at least once
`include "ppm_defines.svh"
`default_nettype none
module peripheral_pin_mux_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic want_cell = 1'h0, want_pci = 1'h0, want_s2 = 1'h0, want_auto = 1'h0;
    logic cell_pin, pci_pin, s2_pin, auto_pin;
    logic [6:0] gp_in = 7'h00;
    logic [6:0] gp_out, gp_oe;
    logic oe_s1, oe_cell, oe_cst, oe_s1st, oe_host, oe_hpci, oe_be0, oe_ecs, oe_s2, oe_s2pci;
    logic always_on;
    ppm_pkg::ppm_sel_t sel;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_errors = 0, n_compared = 0, cycles = 0;

    always #5 sys_clk = ~sys_clk;

    ppm_strap_board board (.sys_clk(sys_clk), .resetn(resetn), .want_cell(want_cell),
        .want_pci(want_pci), .want_s2(want_s2), .want_auto(want_auto), .cell_pin(cell_pin),
        .pci_pin(pci_pin), .s2_pin(s2_pin), .auto_pin(auto_pin));

    ppm_pin_select DUT (.sys_clk(sys_clk), .resetn(resetn), .cell_select_address_pin(cell_pin),
        .pci_select_pin(pci_pin), .serial_two_select_pin(s2_pin),
        .autoinit_address_pin(auto_pin), .upper_gpio_in(gp_in), .upper_gpio_out(gp_out),
        .upper_gpio_oe(gp_oe), .shared_s1_cell_oe_s1(oe_s1), .shared_s1_cell_oe_cell(oe_cell),
        .cell_standalone_oe(oe_cst), .s1_standalone_oe(oe_s1st),
        .shared_host_pci_oe_host(oe_host), .shared_host_pci_oe_pci(oe_hpci),
        .byte_enable_zero_oe(oe_be0), .eeprom_chip_select_oe(oe_ecs),
        .shared_s2_pci_oe_s2(oe_s2), .shared_s2_pci_oe_pci(oe_s2pci), .sel(sel),
        .always_on_en(always_on), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

    task automatic results;
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            $display("MISMATCH t=%0t run did not finish", $time);
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] exp_sel(input logic c, p, s, a);
        return {~c, c, ~p, p, ~(p & ~s), p & ~s, ~p, p & ~s & a};
    endfunction : exp_sel

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] got;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        b_ok = 1'h0;
        got = 2'h3;
        while (!b_ok) begin
            @(negedge sys_clk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            got = bresp;
            @(posedge sys_clk);
            if (aw_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        @(posedge sys_clk);
        chk({31'h0, b_ok}, 32'h1, "write answered");
        chk({30'h0, got}, {30'h0, er}, "bresp");
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_ok, r_ok;
        logic [31:0] got;
        logic [1:0] resp;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        r_ok = 1'h0;
        got = 32'h0;
        resp = 2'h3;
        while (!r_ok) begin
            @(negedge sys_clk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            got = rdata;
            resp = rresp;
            @(posedge sys_clk);
            if (ar_ok) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        @(posedge sys_clk);
        chk({31'h0, r_ok}, 32'h1, "read answered");
        chk(got, ed, "rdata");
        chk({30'h0, resp}, {30'h0, er}, "rresp");
    endtask : axi_read

    task automatic start(input logic c, p, s, a);
        resetn <= 1'h0;
        want_cell <= c;
        want_pci <= p;
        want_s2 <= s;
        want_auto <= a;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'h1;
        repeat (8) @(posedge sys_clk);
    endtask : start

    task automatic check_pins(input logic c, p, s, a);
        chk({24'h0, sel}, {24'h0, exp_sel(c, p, s, a)}, "sel");
        chk({24'h0, oe_s1, oe_cell, oe_cst, oe_s1st, oe_host, oe_hpci, oe_s2, oe_s2pci},
            {24'h0, ~c, c, c, ~c, ~p, p, ~(p & ~s), p & ~s}, "owners");
        chk({31'h0, always_on}, 32'h1, "always on");
        chk({30'h0, oe_be0, oe_ecs}, {30'h0, p, p & ~s}, "pci standalone");
    endtask : check_pins

    task automatic t_configs;
        for (int i = 0; i < 16; i++) begin
            if (i[1] || !i[3]) begin
                start(i[0], i[1], i[2], i[3]);
                check_pins(i[0], i[1], i[2], i[3]);
                axi_read(`PPM_OFF_STRAP, {28'h0, i[3:0]}, `PPM_RESP_OKAY);
                axi_read(`PPM_OFF_SEL, {24'h0, exp_sel(i[0], i[1], i[2], i[3])},
                    `PPM_RESP_OKAY);
            end
        end
    endtask : t_configs

    task automatic t_regs;
        start(1'h1, 1'h1, 1'h1, 1'h0);
        axi_write(`PPM_OFF_STRAP, 32'h0, `PPM_RESP_OKAY);
        axi_read(`PPM_OFF_STRAP, 32'h7, `PPM_RESP_OKAY);
        axi_write(12'h018, 32'h1, `PPM_RESP_SLVERR);
        axi_read(12'h018, 32'h0, `PPM_RESP_SLVERR);
    endtask : t_regs

    task automatic t_gpio(input logic p);
        start(1'h0, p, 1'h1, 1'h0);
        axi_write(`PPM_OFF_GPEN, 32'h3C, `PPM_RESP_OKAY);
        axi_write(`PPM_OFF_GPDIR, 32'h66, `PPM_RESP_OKAY);
        axi_write(`PPM_OFF_GPOUT, 32'h55, `PPM_RESP_OKAY);
        gp_in <= 7'h2B;
        repeat (6) @(posedge sys_clk);
        chk({25'h0, gp_oe}, p ? 32'h0 : 32'h24, "gpio drive");
        chk({25'h0, gp_out}, 32'h55, "gpio out");
        axi_read(`PPM_OFF_GPIN, 32'h2B, `PPM_RESP_OKAY);
        axi_read(`PPM_OFF_GPDIR, 32'h66, `PPM_RESP_OKAY);
    endtask : t_gpio

    task automatic t_live;
        start(1'h0, 1'h1, 1'h0, 1'h1);
        want_s2 <= 1'h1;
        want_cell <= 1'h1;
        repeat (8) @(posedge sys_clk);
        check_pins(1'h0, 1'h1, 1'h1, 1'h1);
        want_s2 <= 1'h0;
        repeat (8) @(posedge sys_clk);
        check_pins(1'h0, 1'h1, 1'h0, 1'h0);
    endtask : t_live

    initial begin
        t_configs();
        t_regs();
        t_gpio(1'h0);
        t_gpio(1'h1);
        t_live();
        results();
    end
endmodule : peripheral_pin_mux_select_bench
`default_nettype wire
